// file: design/slc_pkg.sv
package slc_pkg;

    localparam int SLC_BYTE_W = 8;
    localparam int SLC_SYNC_STAGES = 2;
    localparam logic [3:0] SLC_BIT_LAST = 4'h7;
    localparam logic [3:0] SLC_BIT_ZERO = 4'h0;
    localparam logic SLC_LINE_IDLE = 1'b1;

    typedef enum logic [1:0]
    {
        SLC_TX_IDLE = 2'b00,
        SLC_TX_LOAD = 2'b01,
        SLC_TX_SHIFT = 2'b10
    } slc_tx_state_t;

    typedef enum logic
    {
        SLC_CODE_NRZ = 1'b0,
        SLC_CODE_MANCH = 1'b1
    } slc_code_t;

    typedef struct packed
    {
        logic valid;
        logic [SLC_BYTE_W-1:0] data;
    } slc_byte_t;

endpackage

// file: design/slc_edge_sync.sv
module slc_edge_sync
    import slc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic async_i,
    output logic level_o,
    output logic rise_o,
    output logic fall_o
);
    logic [SLC_SYNC_STAGES-1:0] sync_q;
    logic last_q;

    // The first stage feeds only the second stage to keep metastability contained.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sync_q <= '1;
            last_q <= 1'b1;
        end
        else
        begin
            sync_q <= {sync_q[SLC_SYNC_STAGES-2:0], async_i};
            last_q <= sync_q[SLC_SYNC_STAGES-1];
        end
    end

    assign level_o = sync_q[SLC_SYNC_STAGES-1];
    assign rise_o = level_o & ~last_q;
    assign fall_o = ~level_o & last_q;
endmodule

// file: design/slc_line_coder.sv
// Contract
// - Load byte, shift one bit per clock.
// - NRZ output changes on transmit clock fall.
// - Receive samples on receive clock fall.
// - Receive sample lands in second half.
// - Setup field selects NRZ or Manchester.
// - Manchester sends complement, then true bit.
// - Manchester centre aligns with clock rise.
// - Receive path is always plain NRZ.
// - Line returns high after last cell.
module slc_line_coder
    import slc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic line_code_select_i,
    input wire logic setup_strobe_i,
    input wire slc_pkg::slc_byte_t tx_byte_i,
    output logic tx_ready_o,
    output logic tx_busy_o,
    input wire logic transmit_bit_clock_i,
    output logic tx_data_o,
    input wire logic receive_bit_clock_i,
    input wire logic rx_data_i,
    output slc_pkg::slc_byte_t rx_byte_o,
    output logic code_manch_o
);
    import slc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    logic txc_fall;
    logic txc_rise;
    logic rxc_fall;
    logic rxd_level;

    slc_edge_sync u_txc_sync
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(transmit_bit_clock_i),
        .level_o(),
        .rise_o(txc_rise),
        .fall_o(txc_fall)
    );

    slc_edge_sync u_rxc_sync
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(receive_bit_clock_i),
        .level_o(),
        .rise_o(),
        .fall_o(rxc_fall)
    );

    // Data goes through the same depth as its clock so the fall edge sees aligned data.
    slc_edge_sync u_rxd_sync
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(rx_data_i),
        .level_o(rxd_level),
        .rise_o(),
        .fall_o()
    );

    ////////////////////////////////////////////////////////////////////////////////
    slc_code_t code_q;

    // The mode is only taken on a setup strobe and not mid-byte, to avoid a torn symbol.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            code_q <= SLC_CODE_NRZ;
        end
        else if (setup_strobe_i && !tx_busy_o)
        begin
            code_q <= slc_code_t'(line_code_select_i);
        end
    end

    assign code_manch_o = (code_q == SLC_CODE_MANCH);

    ////////////////////////////////////////////////////////////////////////////////
    slc_tx_state_t state_q;
    logic [SLC_BYTE_W-1:0] shift_q;
    logic [SLC_BYTE_W-1:0] pend_q;
    logic pend_valid_q;
    logic [3:0] bit_q;
    logic tx_q;
    logic load_now;

    // A byte leaves the holding slot only when its first cell starts, so that a byte
    // offered meanwhile cannot overwrite it before it is on the line.
    assign load_now = txc_fall && ((state_q == SLC_TX_LOAD)
        || ((state_q == SLC_TX_SHIFT) && (bit_q == SLC_BIT_LAST) && pend_valid_q));

    // First half of a cell: the complement in Manchester, the bit itself in NRZ.
    function automatic logic cell_open(input logic manch, input logic b);
        return manch ? ~b : b;
    endfunction

    assign tx_ready_o = !pend_valid_q;
    assign tx_busy_o = (state_q != SLC_TX_IDLE) || pend_valid_q;

    // One byte of holding lets the source refill while the current byte shifts.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pend_q <= '0;
            pend_valid_q <= 1'b0;
        end
        else if (tx_byte_i.valid && !pend_valid_q)
        begin
            pend_q <= tx_byte_i.data;
            pend_valid_q <= 1'b1;
        end
        else if (load_now)
        begin
            pend_valid_q <= 1'b0;
        end
    end

    // Each bit cell starts at a transmit clock fall; in Manchester the cell's first half
    // is the complement and the rise marks the centre, where the true value appears.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_q <= SLC_TX_IDLE;
            shift_q <= '0;
            bit_q <= SLC_BIT_ZERO;
            tx_q <= SLC_LINE_IDLE;
        end
        else
        begin
            case (state_q)
                SLC_TX_IDLE:
                begin
                    if (pend_valid_q)
                    begin
                        state_q <= SLC_TX_LOAD;
                    end
                    else if (txc_fall)
                    begin
                        tx_q <= SLC_LINE_IDLE;
                    end
                end
                SLC_TX_LOAD:
                begin
                    if (txc_fall)
                    begin
                        shift_q <= pend_q;
                        bit_q <= SLC_BIT_ZERO;
                        tx_q <= cell_open(code_manch_o, pend_q[0]);
                        state_q <= SLC_TX_SHIFT;
                    end
                end
                SLC_TX_SHIFT:
                begin
                    if (txc_rise && code_manch_o)
                    begin
                        tx_q <= shift_q[0];
                    end
                    else if (txc_fall)
                    begin
                        if (bit_q == SLC_BIT_LAST)
                        begin
                            if (pend_valid_q)
                            begin
                                shift_q <= pend_q;
                                bit_q <= SLC_BIT_ZERO;
                                // The next byte starts in the very next cell, with no idle gap.
                                tx_q <= cell_open(code_manch_o, pend_q[0]);
                                state_q <= SLC_TX_SHIFT;
                            end
                            else
                            begin
                                tx_q <= SLC_LINE_IDLE;
                                state_q <= SLC_TX_IDLE;
                            end
                        end
                        else
                        begin
                            shift_q <= {1'b0, shift_q[SLC_BYTE_W-1:1]};
                            bit_q <= bit_q + 4'h1;
                            tx_q <= cell_open(code_manch_o, shift_q[1]);
                        end
                    end
                end
                default:
                begin
                    state_q <= SLC_TX_IDLE;
                end
            endcase
        end
    end

    assign tx_data_o = tx_q;

    ////////////////////////////////////////////////////////////////////////////////
    logic [SLC_BYTE_W-1:0] rx_shift_q;
    logic [3:0] rx_cnt_q;
    slc_byte_t rx_q;

    // No Manchester decoding here: an external one-shot must supply a clean clock.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rx_shift_q <= '0;
            rx_cnt_q <= SLC_BIT_ZERO;
            rx_q <= '0;
        end
        else
        begin
            rx_q.valid <= 1'b0;
            if (rxc_fall)
            begin
                rx_shift_q <= {rxd_level, rx_shift_q[SLC_BYTE_W-1:1]};
                if (rx_cnt_q == SLC_BIT_LAST)
                begin
                    rx_cnt_q <= SLC_BIT_ZERO;
                    rx_q.valid <= 1'b1;
                    rx_q.data <= {rxd_level, rx_shift_q[SLC_BYTE_W-1:1]};
                end
                else
                begin
                    rx_cnt_q <= rx_cnt_q + 4'h1;
                end
            end
        end
    end

    assign rx_byte_o = rx_q;
endmodule

// file: verification/slc_line_coder_properties.sv
module slc_chk
    import slc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic line_code_select_i,
    input wire logic setup_strobe_i,
    input wire slc_pkg::slc_byte_t tx_byte_i,
    input wire logic tx_ready_o,
    input wire logic tx_busy_o,
    input wire logic transmit_bit_clock_i,
    input wire logic tx_data_o,
    input wire logic receive_bit_clock_i,
    input wire slc_pkg::slc_byte_t rx_byte_o,
    input wire logic code_manch_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // A byte is taken only when offered and the holding slot is free.
    sequence s_take;
        tx_byte_i.valid && tx_ready_o;
    endsequence
    chk_take_busy: assert property (s_take |=> tx_busy_o) else $error("no busy");
    chk_idle_high: assert property (!tx_busy_o |-> tx_data_o) else $error("idle low");
    chk_mode_load: assert property (setup_strobe_i && !tx_busy_o |=>
        code_manch_o == $past(line_code_select_i)) else $error("mode");
    chk_mode_hold: assert property ($changed(code_manch_o) |->
        $past(setup_strobe_i) && !$past(tx_busy_o)) else $error("mode moved");
    chk_nrz_fall: assert property ($changed(tx_data_o) && !code_manch_o |->
        !$past(transmit_bit_clock_i, 2)) else $error("nrz edge");
    chk_rx_pulse: assert property (rx_byte_o.valid |=> !rx_byte_o.valid)
        else $error("rx pulse");
    chk_rx_hold: assert property ($changed(rx_byte_o.data) |-> rx_byte_o.valid)
        else $error("rx data");
    chk_rx_fall: assert property (rx_byte_o.valid |-> !$past(receive_bit_clock_i, 2))
        else $error("rx edge");
endmodule

// file: verification/slc_far_end.sv
module slc_far_end
(
    output logic txc_o,
    output logic rxc_o,
    output logic rxd_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic tx_run = 1'b0;
    initial {txc_o, rxc_o, rxd_o} = 3'h7;
    // Both bit clocks rest high between frames, as the far end clocks only while busy.
    always #200 if (tx_run || !txc_o) txc_o = ~txc_o;
    task automatic send(input logic [7:0] b);
        for (int i = 0; i < 8; i++)
        begin
            rxd_o = b[i];
            rxc_o = 1'b1;
            #200 rxc_o = 1'b0;
            #200;
        end
        rxd_o = ~b[7];
        rxc_o = 1'b1;
    endtask
endmodule

// file: verification/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import slc_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic line_code_select_i = 1'b0;
    logic setup_strobe_i = 1'b0;
    slc_byte_t tx_byte_i = '0;
    slc_byte_t rx_byte_o;
    logic tx_ready_o, tx_busy_o, tx_data_o, code_manch_o, transmit_bit_clock, receive_bit_clock, rx_data_i;
    logic [7:0] rx_seen = 8'h00;
    int fails = 0;
    int check_count = 0;
    always #25 clk_i = ~clk_i;
    slc_line_coder dut_u (.clk_i, .rst_i, .line_code_select_i, .setup_strobe_i, .tx_byte_i,
        .tx_ready_o, .tx_busy_o, .transmit_bit_clock_i(transmit_bit_clock), .tx_data_o,
        .receive_bit_clock_i(receive_bit_clock), .rx_data_i, .rx_byte_o, .code_manch_o);
    slc_far_end far_u (.txc_o(transmit_bit_clock), .rxc_o(receive_bit_clock), .rxd_o(rx_data_i));
    always @(posedge clk_i) if (rx_byte_o.valid === 1'b1) rx_seen <= rx_byte_o.data;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic setup(input logic m);
        @(posedge clk_i) #1 line_code_select_i = m;
        setup_strobe_i = 1'b1;
        @(posedge clk_i) #1 setup_strobe_i = 1'b0;
    endtask
    // Sampling at bit clock edges sees the cell just ending, before the coder reacts.
    task automatic xfer(input logic m, input logic [7:0] d);
        logic [8:0] e = {1'b1, d};
        setup(m);
        tx_byte_i = '{1'b1, d};
        while (tx_ready_o !== 1'b1) @(posedge clk_i) #1;
        @(posedge clk_i) #1 tx_byte_i.valid = 1'b0;
        setup(!m);
        check(8'(code_manch_o), 8'(m));
        far_u.tx_run = 1'b1;
        for (int n = 1; n < 11; n++)
        begin
            @(negedge transmit_bit_clock);
            if (n > 1) check(8'(tx_data_o), 8'(e[n-2]));
            if (m && n < 9)
                @(posedge transmit_bit_clock) check(8'(tx_data_o), 8'(!e[n-1]));
        end
        far_u.tx_run = 1'b0;
        far_u.send(~d);
        repeat (8) @(posedge clk_i);
        check(rx_seen, ~d);
        $display("xfer %h mode %b done", d, m);
    endtask
    // Two bytes back to back: the second must follow the first with no idle cell.
    task automatic burst(input logic m, input logic [7:0] a, input logic [7:0] b);
        logic [16:0] e = {1'b1, b, a};
        setup(m);
        tx_byte_i = '{1'b1, a};
        @(posedge clk_i) #1 tx_byte_i = '{1'b1, b};
        far_u.tx_run = 1'b1;
        while (tx_ready_o !== 1'b1) @(posedge clk_i) #1;
        @(posedge clk_i) #1 tx_byte_i.valid = 1'b0;
        for (int n = 2; n < 19; n++)
        begin
            @(negedge transmit_bit_clock);
            check(8'(tx_data_o), 8'(e[n-2]));
            if (m && n < 17)
                @(posedge transmit_bit_clock) check(8'(tx_data_o), 8'(!e[n-1]));
        end
        far_u.tx_run = 1'b0;
        $display("burst %h %h mode %b done", a, b, m);
    endtask
    task automatic results();
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(posedge clk_i);
        #1 rst_i = 1'b0;
        check(8'({tx_data_o, tx_ready_o, tx_busy_o, code_manch_o}), 8'hC);
        xfer(1'b0, 8'h96);
        xfer(1'b1, 8'h4B);
        xfer(1'b0, 8'h01);
        burst(1'b0, 8'hF0, 8'h0F);
        burst(1'b1, 8'h3C, 8'hA5);
        results();
    end
    // Three transfers and two bursts need about 40 us, so this limit leaves a wide margin.
    initial
    begin
        #100000 fails++;
        results();
    end
endmodule

bind slc_line_coder slc_chk chk_u (.clk_i, .rst_i, .line_code_select_i, .setup_strobe_i,
    .tx_byte_i, .tx_ready_o, .tx_busy_o, .transmit_bit_clock_i, .tx_data_o,
    .receive_bit_clock_i, .rx_byte_o, .code_manch_o);
